// ---- ctn_pkg.sv ----
// Constants, register map and field layout of the thermal and thermistor config bank
package ctn_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL5 = 8'h14;
    localparam logic [7:0] ADDR_RSVD = 8'h15;
    localparam logic [7:0] ADDR_TEMP = 8'h16;
    localparam logic [7:0] ADDR_DERATE = 8'h17;
    localparam logic [7:0] ADDR_THRESH = 8'h18;
    localparam int CFG_NUM = 4;
    localparam logic [7:0] CFG_ADDR [CFG_NUM] = '{ADDR_CTRL5, ADDR_TEMP, ADDR_DERATE, ADDR_THRESH};
    // Reset values
    localparam logic [7:0] CFG_RST [CFG_NUM] = '{8'h00, 8'hc0, 8'h7a, 8'h54};
    // Writable bits; reserved bits are never written
    localparam logic [7:0] CFG_WMASK [CFG_NUM] = '{8'h01, 8'hfe, 8'hfe, 8'hff};
    // Bits restored on watchdog expiry
    localparam logic [7:0] CFG_WDOG [CFG_NUM] = '{8'h01, 8'hf0, 8'hfe, 8'hff};
    localparam int IDX_CTRL5 = 0;
    localparam int IDX_TEMP = 1;
    localparam int IDX_DERATE = 2;
    localparam int IDX_THRESH = 3;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int POS_DISCH_OC = 0;
    localparam int POS_THERM_REG = 6;
    localparam int POS_THERM_SHUT = 4;
    localparam int POS_BUS_PD = 3;
    localparam int POS_AUX1_PD = 2;
    localparam int POS_AUX2_PD = 1;
    localparam int POS_WARM_V = 5;
    localparam int POS_WARM_I = 3;
    localparam int POS_COOL_I = 1;
    localparam int POS_COOL_TH = 6;
    localparam int POS_WARM_TH = 4;
    localparam int POS_HOT_LIM = 2;
    localparam int POS_COLD_LIM = 1;
    localparam int POS_TS_OVR = 0;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [3:0] TS_NORMAL = 4'h0;
    // Serial bus bit count per byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Bus address of this device; the value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h3a;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_AACK = 4'b0010,
        ST_PTR = 4'b0011,
        ST_WDATA = 4'b0100,
        ST_WACK = 4'b0101,
        ST_RDATA = 4'b0110,
        ST_RACK = 4'b0111
    } ctn_state_e;
endpackage : ctn_pkg

// ---- ctn_wr_if.sv ----
// Internal register write strobe carrier
interface ctn_wr_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wdog;
    logic reg_rst;
    modport src (output wr_en, output wr_addr, output wr_data, output wdog, output reg_rst);
    modport dst (input wr_en, input wr_addr, input wr_data, input wdog, input reg_rst);
endinterface : ctn_wr_if

// ---- ctn_cfg_reg.sv ----
// One configuration register with write mask and two reset sources
module ctn_cfg_reg
    import ctn_pkg::*;
#(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] WDOG = 8'hff
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    ctn_wr_if.dst bus,
    output logic [7:0] o_q
);
    logic [7:0] q_reg;
    logic [7:0] q_next;

    always_comb begin
        q_next = q_reg;
        if (bus.reg_rst) begin
            q_next = RST;
        end else if (bus.wdog) begin
            // Pull-down enables sit outside WDOG and survive expiry
            q_next = (q_reg & ~WDOG) | (RST & WDOG);
        end else if (bus.wr_en && bus.wr_addr == ADDR) begin
            q_next = (q_reg & ~WMASK) | (bus.wr_data & WMASK);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            q_reg <= RST;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;

    rsvd_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_q & ~WMASK & ~RST) == 8'h00) else $error("reserved bit set");
    wdog_restore_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        bus.wdog && !bus.reg_rst |=> ((o_q & WDOG) == (RST & WDOG))
            && ((o_q & ~WDOG) == $past(o_q & ~WDOG))) else $error("watchdog restore wrong");
    reg_rst_val_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        bus.reg_rst |=> o_q == RST) else $error("register reset value wrong");
    write_lands_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        bus.wr_en && bus.wr_addr == ADDR && !bus.wdog && !bus.reg_rst
            |=> o_q == (($past(o_q) & ~WMASK) | ($past(bus.wr_data) & WMASK)))
        else $error("write not stored");
endmodule : ctn_cfg_reg

// ---- ctn_ts_mask.sv ----
// Thermistor status override stage
module ctn_ts_mask
    import ctn_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_override,
    input wire logic [3:0] i_status,
    input wire logic i_good,
    output logic [3:0] o_status,
    output logic o_good
);
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic good_reg;
    logic good_next;

    always_comb begin
        status_next = i_override ? TS_NORMAL : i_status;
        good_next = i_override | i_good;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            status_reg <= TS_NORMAL;
            good_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            good_reg <= good_next;
        end
    end

    assign o_status = status_reg;
    assign o_good = good_reg;

    ts_force_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_override |=> o_status == TS_NORMAL && o_good) else $error("override not applied");
    ts_pass_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_override |=> o_status == $past(i_status) && o_good == $past(i_good))
        else $error("status not passed");
    ts_override_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_override && i_status != TS_NORMAL);
endmodule : ctn_ts_mask

// ---- ctn_thermal_cfg.sv ----
// Serial-bus reachable thermal and thermistor configuration bank
module ctn_thermal_cfg
    import ctn_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_wdog_expire,
    input wire logic i_reg_rst,
    input wire logic [3:0] i_ts_status,
    input wire logic i_ts_good,
    output logic [3:0] o_ts_status,
    output logic o_ts_good,
    output logic o_discharge_overcurrent_enable,
    output logic [1:0] o_thermal_regulation_threshold,
    output logic [1:0] o_thermal_shutdown_threshold,
    output logic o_input_bus_pulldown_enable,
    output logic o_aux_input_one_pulldown_enable,
    output logic o_aux_input_two_pulldown_enable,
    output logic [2:0] o_warm_range_voltage_setting,
    output logic [1:0] o_warm_range_current_setting,
    output logic [1:0] o_cool_range_current_setting,
    output logic [1:0] o_cool_comparator_threshold,
    output logic [1:0] o_warm_comparator_threshold,
    output logic [1:0] o_output_mode_hot_limit,
    output logic o_output_mode_cold_limit,
    output logic o_thermistor_override
);
    // ****************************************
    // Register bank
    // ****************************************
    ctn_wr_if wbus ();
    logic [7:0] cfg_q [CFG_NUM];

    // Each register carries its own address, write mask and watchdog set
    genvar gi;
    generate
        for (gi = 0; gi < CFG_NUM; gi++) begin : g_cfg
            ctn_cfg_reg #(
                .ADDR(CFG_ADDR[gi]),
                .RST(CFG_RST[gi]),
                .WMASK(CFG_WMASK[gi]),
                .WDOG(CFG_WDOG[gi])
            ) u_reg (
                .i_ref_clk(i_ref_clk),
                .i_sys_rst(i_sys_rst),
                .bus(wbus),
                .o_q(cfg_q[gi])
            );
        end
    endgenerate

    // Unmapped and reserved addresses read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] r;
        r = RD_ZERO;
        for (int k = 0; k < CFG_NUM; k++) begin
            if (a == CFG_ADDR[k]) begin
                r = cfg_q[k];
            end
        end
        return r;
    endfunction : rd_byte

    // ****************************************
    // Serial bus slave
    // ****************************************
    ctn_state_e state_reg, state_next;
    logic scl_reg, scl_next, sda_reg, sda_next;
    logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] ptr_reg, ptr_next;
    logic drive_reg, drive_next;
    logic wr_reg, wr_next;
    logic [7:0] wa_reg, wa_next, wd_reg, wd_next;
    logic start_c, stop_c, rise_c, fall_c, done_c;
    logic [7:0] rd_now;

    // A start or stop is only seen while SCL stands high
    assign start_c = scl_reg && sda_d_reg && !sda_reg;
    assign stop_c = scl_reg && !sda_d_reg && sda_reg;
    assign rise_c = scl_reg && !scl_d_reg;
    assign fall_c = !scl_reg && scl_d_reg;
    assign done_c = cnt_reg == BITS_PER_BYTE;
    assign rd_now = rd_byte(ptr_reg);

    always_comb begin
        state_next = state_reg;
        scl_next = i_scl;
        sda_next = i_sda;
        scl_d_next = scl_reg;
        sda_d_next = sda_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        drive_next = drive_reg;
        // Write strobe lasts one cycle; reset and watchdog still win over it
        wr_next = 1'b0;
        wa_next = wa_reg;
        wd_next = wd_reg;
        if (stop_c) begin
            state_next = ST_IDLE;
            drive_next = 1'b0;
        end else if (start_c) begin
            state_next = ST_ADDR;
            cnt_next = '0;
            drive_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (rise_c && !done_c) begin
                        sh_next = {sh_reg[6:0], sda_reg};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall_c && done_c) begin
                        drive_next = 1'b1;
                        if (state_reg == ST_ADDR) begin
                            // Foreign address: stay silent until the next start
                            state_next = (sh_reg[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
                            drive_next = sh_reg[7:1] == DEV_ADDR;
                        end else if (state_reg == ST_PTR) begin
                            ptr_next = sh_reg;
                            state_next = ST_WACK;
                        end else begin
                            wr_next = 1'b1;
                            wa_next = ptr_reg;
                            wd_next = sh_reg;
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_WACK;
                        end
                    end
                end
                ST_AACK: begin
                    if (fall_c) begin
                        cnt_next = '0;
                        if (sh_reg[0]) begin
                            sh_next = rd_now;
                            drive_next = !rd_now[7];
                            state_next = ST_RDATA;
                        end else begin
                            drive_next = 1'b0;
                            state_next = ST_PTR;
                        end
                    end
                end
                ST_WACK: begin
                    if (fall_c) begin
                        drive_next = 1'b0;
                        cnt_next = '0;
                        state_next = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (rise_c) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall_c) begin
                        if (done_c) begin
                            drive_next = 1'b0;
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_RACK;
                        end else begin
                            drive_next = !sh_reg[3'(4'h7 - cnt_reg)];
                        end
                    end
                end
                ST_RACK: begin
                    if (rise_c && sda_reg) begin
                        state_next = ST_IDLE;
                    end else if (fall_c) begin
                        cnt_next = '0;
                        sh_next = rd_now;
                        drive_next = !rd_now[7];
                        state_next = ST_RDATA;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            cnt_reg <= '0;
            sh_reg <= '0;
            ptr_reg <= '0;
            drive_reg <= 1'b0;
            wr_reg <= 1'b0;
            wa_reg <= '0;
            wd_reg <= '0;
        end else begin
            state_reg <= state_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            drive_reg <= drive_next;
            wr_reg <= wr_next;
            wa_reg <= wa_next;
            wd_reg <= wd_next;
        end
    end

    // ****************************************
    // Pin and strobe outputs
    // ****************************************
    // Open drain: only ever pulls low
    assign o_sda = 1'b0;
    assign o_sda_oe_n = !drive_reg;
    assign wbus.wr_en = wr_reg;
    assign wbus.wr_addr = wa_reg;
    assign wbus.wr_data = wd_reg;
    assign wbus.wdog = i_wdog_expire;
    assign wbus.reg_rst = i_reg_rst;

    // ****************************************
    // Field outputs
    // ****************************************
    ctn_ts_mask u_ts (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_override(cfg_q[IDX_THRESH][POS_TS_OVR]),
        .i_status(i_ts_status),
        .i_good(i_ts_good),
        .o_status(o_ts_status),
        .o_good(o_ts_good)
    );

    assign o_discharge_overcurrent_enable = cfg_q[IDX_CTRL5][POS_DISCH_OC];
    assign o_thermal_regulation_threshold = cfg_q[IDX_TEMP][POS_THERM_REG +: 2];
    assign o_thermal_shutdown_threshold = cfg_q[IDX_TEMP][POS_THERM_SHUT +: 2];
    assign o_input_bus_pulldown_enable = cfg_q[IDX_TEMP][POS_BUS_PD];
    assign o_aux_input_one_pulldown_enable = cfg_q[IDX_TEMP][POS_AUX1_PD];
    assign o_aux_input_two_pulldown_enable = cfg_q[IDX_TEMP][POS_AUX2_PD];
    assign o_warm_range_voltage_setting = cfg_q[IDX_DERATE][POS_WARM_V +: 3];
    assign o_warm_range_current_setting = cfg_q[IDX_DERATE][POS_WARM_I +: 2];
    assign o_cool_range_current_setting = cfg_q[IDX_DERATE][POS_COOL_I +: 2];
    assign o_cool_comparator_threshold = cfg_q[IDX_THRESH][POS_COOL_TH +: 2];
    assign o_warm_comparator_threshold = cfg_q[IDX_THRESH][POS_WARM_TH +: 2];
    assign o_output_mode_hot_limit = cfg_q[IDX_THRESH][POS_HOT_LIM +: 2];
    assign o_output_mode_cold_limit = cfg_q[IDX_THRESH][POS_COLD_LIM];
    assign o_thermistor_override = cfg_q[IDX_THRESH][POS_TS_OVR];

    // ****************************************
    // Checks
    // ****************************************
    rsvd_read_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ptr_reg == ADDR_RSVD |-> rd_now == RD_ZERO) else $error("reserved reads nonzero");
    disch_oc_wdog_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_wdog_expire |=> !o_discharge_overcurrent_enable) else $error("overcurrent bit kept");
    pd_survive_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_wdog_expire && !i_reg_rst |=> $stable(o_input_bus_pulldown_enable)
            && $stable(o_aux_input_one_pulldown_enable)
            && $stable(o_aux_input_two_pulldown_enable)) else $error("pull-down lost on watchdog");
    wdog_defaults_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_wdog_expire ##1 !i_reg_rst[*1] |-> o_warm_range_voltage_setting == 3'h3
            && o_cool_range_current_setting == 2'h1 && o_output_mode_hot_limit == 2'h1
            && o_thermal_regulation_threshold == 2'h3 && o_thermal_shutdown_threshold == 2'h0
            && o_warm_range_current_setting == 2'h3 && o_cool_comparator_threshold == 2'h1
            && o_warm_comparator_threshold == 2'h1 && !o_output_mode_cold_limit
            && !o_thermistor_override) else $error("watchdog defaults wrong");
    ack_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state_reg == ST_WACK |-> !o_sda_oe_n) else $error("no acknowledge");
    stop_release_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        stop_c |=> o_sda_oe_n && state_reg == ST_IDLE) else $error("stop not honoured");
    reg_rst_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_rst |=> !o_input_bus_pulldown_enable && !o_aux_input_one_pulldown_enable
            && !o_aux_input_two_pulldown_enable) else $error("pull-down kept on reset");
    ts_override_out_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_thermistor_override |=> o_ts_status == TS_NORMAL && o_ts_good) else $error("no override");
    idle_release_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state_reg == ST_IDLE |-> o_sda_oe_n) else $error("line pulled while idle");
    wr_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_reg |=> !wr_reg) else $error("write strobe too long");

    // ****************************************
    // Coverage
    // ****************************************
    write_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_reg && wa_reg == ADDR_THRESH);
    rsvd_write_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_reg && wa_reg == ADDR_RSVD);
    read_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state_reg == ST_RACK ##[1:40] state_reg == ST_RDATA);
    wdog_keep_pd_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_wdog_expire && o_input_bus_pulldown_enable);
endmodule : ctn_thermal_cfg

// ---- ctn_host_model.sv ----
// Serial bus host model that issues register writes and reads to the bank
module ctn_host_model
    import ctn_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_rd_valid = 1'b0;
        o_rd_data = 8'h00;
    end
    // ****************************************
    // Bus conditions
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : tick
    // Also serves as repeated start: SDA rises only while SCL is low
    task automatic start_cond();
        o_scl <= 1'b0;
        tick(4);
        o_sda <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b0;
        tick(4);
    endtask : start_cond
    task automatic stop_cond();
        o_scl <= 1'b0;
        tick(4);
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b1;
        tick(4);
    endtask : stop_cond
    // Four clocks per quarter keeps SDA steady well beyond three clocks around SCL edges
    task automatic bit_xfer(input logic b, output logic s);
        o_scl <= 1'b0;
        tick(4);
        o_sda <= b;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        s = i_sda;
        tick(4);
    endtask : bit_xfer
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                             output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], q[i]);
        end
        bit_xfer(ack_in, ack);
    endtask : byte_xfer
    // ****************************************
    // Register transfers
    // ****************************************
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$], output logic nak);
        logic [7:0] q;
        logic a;
        start_cond();
        byte_xfer({DEV_ADDR, 1'b0}, 1'b1, q, nak);
        byte_xfer(ptr, 1'b1, q, a);
        nak |= a;
        foreach (d[i]) begin
            byte_xfer(d[i], 1'b1, q, a);
            nak |= a;
        end
        stop_cond();
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input int n, output logic nak);
        logic [7:0] q;
        logic a;
        start_cond();
        byte_xfer({DEV_ADDR, 1'b0}, 1'b1, q, nak);
        byte_xfer(ptr, 1'b1, q, a);
        nak |= a;
        start_cond();
        byte_xfer({DEV_ADDR, 1'b1}, 1'b1, q, a);
        nak |= a;
        for (int i = 0; i < n; i++) begin
            byte_xfer(8'hff, (i == n - 1), q, a);
            o_rd_data <= q;
            o_rd_valid <= 1'b1;
            tick(1);
            o_rd_valid <= 1'b0;
        end
        stop_cond();
    endtask : rd
endmodule : ctn_host_model

// ---- ctn_thermal_cfg_tb.sv ----
// Self-checking bench of the thermal and thermistor configuration bank
module ctn_thermal_cfg_tb
    import ctn_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic wdog = 1'b0;
    logic reg_rst = 1'b0;
    logic [3:0] ts_in = 4'h0;
    logic ts_good_in = 1'b0;
    logic scl, sda_host, sda_dev, oe_n, rd_valid, ts_good;
    logic [7:0] rd_data;
    logic [3:0] ts_out;
    wire [22:0] fld;
    logic [7:0] exp_q [$];
    int failures = 0;
    int n_compared = 0;
    // Pull-up on the wire: it is low only while someone pulls it low
    wire sda_line = sda_host & (oe_n | sda_dev);
    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    ctn_host_model u_ctn_host_model (.i_ref_clk(i_ref_clk), .i_sda(sda_line), .o_scl(scl),
        .o_sda(sda_host), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    ctn_thermal_cfg u_ctn_thermal_cfg (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_scl(scl), .i_sda(sda_line), .o_sda(sda_dev), .o_sda_oe_n(oe_n),
        .i_wdog_expire(wdog), .i_reg_rst(reg_rst), .i_ts_status(ts_in), .i_ts_good(ts_good_in),
        .o_ts_status(ts_out), .o_ts_good(ts_good), .o_discharge_overcurrent_enable(fld[22]),
        .o_thermal_regulation_threshold(fld[21:20]), .o_thermal_shutdown_threshold(fld[19:18]),
        .o_input_bus_pulldown_enable(fld[17]), .o_aux_input_one_pulldown_enable(fld[16]),
        .o_aux_input_two_pulldown_enable(fld[15]), .o_warm_range_voltage_setting(fld[14:12]),
        .o_warm_range_current_setting(fld[11:10]), .o_cool_range_current_setting(fld[9:8]),
        .o_cool_comparator_threshold(fld[7:6]), .o_warm_comparator_threshold(fld[5:4]),
        .o_output_mode_hot_limit(fld[3:2]), .o_output_mode_cold_limit(fld[1]),
        .o_thermistor_override(fld[0]));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic wr_chk(input logic [7:0] ptr, input logic [7:0] d [$]);
        logic nak;
        u_ctn_host_model.wr(ptr, d, nak);
        `CHK("write ack", 1'b0, nak)
    endtask : wr_chk
    // Expected bytes are noted first; the monitor compares them as they arrive
    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e [$]);
        logic nak;
        foreach (e[i]) exp_q.push_back(e[i]);
        u_ctn_host_model.rd(ptr, e.size(), nak);
        `CHK("read ack", 1'b0, nak)
    endtask : rd_chk
    task automatic chk_fields(input logic [7:0] r14, r16, r17, r18);
        `CHK("fields", {r14[0], r16[7:1], r17[7:1], r18}, fld)
    endtask : chk_fields
    task automatic pulse(input logic is_wdog);
        @(posedge i_ref_clk);
        if (is_wdog) wdog <= 1'b1; else reg_rst <= 1'b1;
        @(posedge i_ref_clk);
        wdog <= 1'b0;
        reg_rst <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
    endtask : pulse
    always @(posedge i_ref_clk) begin
        logic [7:0] e;
        if (rd_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK("read data", e, rd_data)
        end
    end
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        failures++;
        $display("timeout");
        final_report();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [7:0] r [$];
        logic [7:0] w16, w17, w18;
        repeat (12) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        void'($urandom(32'ha1189b15));
        rd_chk(8'h14, '{8'h00, 8'h00, 8'hc0, 8'h7a, 8'h54});
        chk_fields(8'h00, 8'hc0, 8'h7a, 8'h54);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) r.push_back(8'($urandom));
        wr_chk(8'h14, r);
        rd_chk(8'h14, '{r[0] & 8'h01, 8'h00, r[2] & 8'hfe, r[3] & 8'hfe, r[4]});
        chk_fields(r[0], r[2], r[3], r[4]);
        $display("test masked writes done");
        wr_chk(8'h14, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
        pulse(1'b1);
        chk_fields(8'h00, 8'hce, 8'h7a, 8'h54);
        rd_chk(8'h16, '{8'hce});
        pulse(1'b0);
        chk_fields(8'h00, 8'hc0, 8'h7a, 8'h54);
        $display("test watchdog and register reset done");
        for (int k = 0; k < 8; k++) begin
            w16 = {k[1:0], k[1:0], k[2:0], 1'b0};
            w17 = {k[2:0], k[1:0], k[1:0], 1'b0};
            w18 = {k[1:0], k[1:0], k[1:0], k[0], k[1]};
            wr_chk(8'h16, '{w16, w17, w18});
            chk_fields(8'h00, w16, w17, w18);
        end
        $display("test field codes done");
        wr_chk(8'h18, '{8'h54});
        ts_in <= 4'($urandom) | 4'h1;
        ts_good_in <= 1'($urandom);
        repeat (3) @(posedge i_ref_clk);
        `CHK("ts pass", {ts_in, ts_good_in}, {ts_out, ts_good})
        wr_chk(8'h18, '{8'h55});
        ts_in <= 4'hf;
        ts_good_in <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        `CHK("ts override", {TS_NORMAL, 1'b1}, {ts_out, ts_good})
        $display("test thermistor override done");
        final_report();
    end
endmodule : ctn_thermal_cfg_tb
